// ==== rtl/bcc_pkg.sv ====
/*
 Package for the battery charger control block: register offsets,
 field positions, reset values, charger modes, strap levels, setting
 codes and the trickle timeout.
 Assumes a single 100 MHz clock and a synchronous active-low reset.
*/
package bcc_pkg;

   // Register offsets (word index on the plain register port)
   localparam logic [3:0] BCC_OFS_CTRL = 4'h0;
   localparam logic [3:0] BCC_OFS_CHG = 4'h1;
   localparam logic [3:0] BCC_OFS_STATUS = 4'h2;
   localparam logic [3:0] BCC_OFS_COIN = 4'h3;

   // Control register fields
   localparam int BCC_CTRL_CHG_EN = 0;   // Software enables normal charging
   localparam int BCC_CTRL_TRK_STOP = 1; // Write 1: stop trickle (pulse)
   localparam int BCC_CTRL_ACC_SUP = 2;  // Supply an accessory from battery
   localparam int BCC_CTRL_DONE = 3;     // Charge completion indication

   // Charge settings register fields
   localparam int BCC_CHG_VSEL_LSB = 0;  // 3 bits, eight voltage steps
   localparam int BCC_CHG_ISEL_LSB = 4;  // 4 bits, 0..14 steps, 15 fully on
   localparam int BCC_CHG_TSEL_LSB = 8;  // 3 bits, trickle current code

   // Coin cell register fields
   localparam int BCC_COIN_VSEL_LSB = 0; // 3 bits, coin cell voltage

   // Reset values
   localparam logic [31:0] BCC_CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] BCC_CHG_RST = 32'h0000_0000;
   localparam logic [2:0] BCC_COIN_RST = 3'h0;

   // Setting codes
   localparam logic [3:0] BCC_ISEL_FULL_ON = 4'hf;
   localparam logic [3:0] BCC_ISEL_MAX_STEP = 4'he;
   localparam logic [2:0] BCC_TSEL_70MA = 3'h6;   // Nearest code to 70 mA (72 mA)
   localparam logic [2:0] BCC_TSEL_MAX = 3'h7;    // 84 mA in 12 mA steps

   // Standalone trickle timeout in milliseconds and in cycles
   localparam int BCC_CLK_MHZ = 100;
   localparam int BCC_TRK_TIMEOUT_MS = 1000;
   localparam int BCC_TRK_TIMEOUT_CYC = BCC_TRK_TIMEOUT_MS * 1000 * BCC_CLK_MHZ;

   // Three-level strap reading
   typedef enum logic [1:0] {
      BCC_LVL_GND,
      BCC_LVL_HIZ,
      BCC_LVL_HIGH,
      BCC_LVL_BAD
   } bcc_level_t;

   // Decoded charger modes
   typedef enum logic [2:0] {
      BCC_MODE_DUAL,
      BCC_MODE_SINGLE,
      BCC_MODE_SERIAL,
      BCC_MODE_SEP_DUAL,
      BCC_MODE_SEP_SINGLE,
      BCC_MODE_SEP_SERIAL,
      BCC_MODE_RESERVED
   } bcc_mode_t;

   // Battery comparator results from the analog side
   typedef struct packed {
      logic charger_valid;
      logic charger_over_volt;
      logic batt_present;
      logic above_low;
      logic above_operate;
   } bcc_sense_t;

   // Pass transistor and source drive
   typedef struct packed {
      logic charge_control_fet;
      logic charger_clamp_fet;
      logic battery_switch_fet;
      logic trickle_src_en;
   } bcc_fet_t;

endpackage

// ==== rtl/bcc_strap_decode.sv ====
/*
 Three-level strap decoder for the two charger-mode pins.
 Assumes each pin arrives as a pair of comparator bits that are already
 synchronised to the clock: above-high and below-low.
*/
module bcc_strap_decode
   import bcc_pkg::*;
(
   // Strap comparator bits
   input wire logic upper_hi_in,
   input wire logic upper_lo_in,
   input wire logic lower_hi_in,
   input wire logic lower_lo_in,
   // Decoded mode
   output bcc_mode_t mode_out
);

   bcc_level_t upper;
   bcc_level_t lower;

   // Fold each comparator pair into one level
   function automatic bcc_level_t level_of(input logic hi, input logic lo);
      if (hi && !lo) begin
         return BCC_LVL_HIGH;
      end else if (lo && !hi) begin
         return BCC_LVL_GND;
      end else if (!hi && !lo) begin
         return BCC_LVL_HIZ;
      end
      return BCC_LVL_BAD;
   endfunction

   always_comb begin
      upper = level_of(upper_hi_in, upper_lo_in);
      lower = level_of(lower_hi_in, lower_lo_in);
      mode_out = BCC_MODE_RESERVED;
      if (upper == BCC_LVL_HIZ) begin
         unique case (lower)
            BCC_LVL_GND: mode_out = BCC_MODE_DUAL;
            BCC_LVL_HIZ: mode_out = BCC_MODE_SINGLE;
            BCC_LVL_HIGH: mode_out = BCC_MODE_SERIAL;
            default: mode_out = BCC_MODE_RESERVED;
         endcase
      end else if (upper == BCC_LVL_HIGH) begin
         unique case (lower)
            BCC_LVL_GND: mode_out = BCC_MODE_SEP_DUAL;
            BCC_LVL_HIZ: mode_out = BCC_MODE_SEP_SINGLE;
            BCC_LVL_HIGH: mode_out = BCC_MODE_SEP_SERIAL;
            default: mode_out = BCC_MODE_RESERVED;
         endcase
      end
   end

endmodule

// ==== rtl/bcc_top.sv ====
/*
 Battery charger control: strap decode, standalone trickle sequence,
 charge settings, pass transistor pattern and coin cell control.
 Assumes comparator inputs come from the analog side asynchronously
 and are synchronised here; software uses the plain register port.
*/
// Decided for this implementation: the address map and the strobed register port.
module bcc_top
   import bcc_pkg::*;
#(
   parameter int TRK_TIMEOUT_CYC = BCC_TRK_TIMEOUT_CYC
)
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rstn_in,
   // Register port
   input wire logic [3:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [31:0] reg_rdata_out,
   // Strap comparators, asynchronous
   input wire logic strap_upper_hi_in,
   input wire logic strap_upper_lo_in,
   input wire logic strap_lower_hi_in,
   input wire logic strap_lower_lo_in,
   // Analog sense, asynchronous
   input wire bcc_sense_t sense_in,
   input wire logic usb_both_lines_high_in,
   // Power state: 1 when the application is on
   input wire logic power_on_in,
   // Drive outputs
   output bcc_fet_t fet_out,
   output logic [2:0] charge_vsel_out,
   output logic [3:0] charge_isel_out,
   output logic [2:0] trickle_isel_out,
   output logic power_up_req_out,
   output logic dead_batt_ok_out,
   output logic [2:0] coin_vsel_out,
   output logic coin_low_ilim_out
);

   typedef enum logic [1:0] {
      BCC_ST_IDLE,
      BCC_ST_TRICKLE,
      BCC_ST_NORMAL,
      BCC_ST_DONE
   } bcc_state_t;

   localparam int SYNC_W = 11;
   localparam logic [31:0] TMO_LAST = 32'(TRK_TIMEOUT_CYC - 1);

   // Synchroniser stages: first rank read only by second rank
   logic [SYNC_W-1:0] sync1;
   logic [SYNC_W-1:0] sync2;
   bcc_sense_t sense;
   logic usb_high;
   logic pwr_on;
   bcc_mode_t strap_mode;
   bcc_mode_t mode;
   logic strap_taken;
   bcc_state_t state;
   bcc_state_t next_state;
   logic [31:0] tmo_cnt;
   logic [31:0] ctrl;
   logic [31:0] chg;
   logic [2:0] coin_prog;
   logic stop_pulse;
   logic single_path;
   logic trickle_allowed;
   logic valid_q;

   // Two-flop synchroniser for all asynchronous inputs
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         sync1 <= '0;
         sync2 <= '0;
      end else begin
         sync1 <= {strap_upper_hi_in, strap_upper_lo_in, strap_lower_hi_in,
                   strap_lower_lo_in, sense_in, usb_both_lines_high_in,
                   power_on_in};
         sync2 <= sync1;
      end
   end

   assign sense = sync2[6:2];
   assign usb_high = sync2[1];
   assign pwr_on = sync2[0];

   bcc_strap_decode u_strap (
      .upper_hi_in(sync2[10]),
      .upper_lo_in(sync2[9]),
      .lower_hi_in(sync2[8]),
      .lower_lo_in(sync2[7]),
      .mode_out(strap_mode)
   );

   // latch mode once
   // Waits for the synchroniser to fill so the strap value is settled
   logic [1:0] strap_wait;
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         strap_wait <= 2'h0;
         strap_taken <= 1'b0;
         mode <= BCC_MODE_RESERVED;
      end else if (!strap_taken) begin
         strap_wait <= strap_wait + 2'h1;
         if (strap_wait == 2'h2) begin
            mode <= strap_mode;
            strap_taken <= 1'b1;
         end
      end
   end

   assign single_path = (mode == BCC_MODE_SINGLE) ||
                        (mode == BCC_MODE_SEP_SINGLE);
   assign trickle_allowed = strap_taken && (mode != BCC_MODE_RESERVED) &&
                            !(single_path && usb_high);

   // Register writes; the stop bit is a pulse and never stored
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         ctrl <= BCC_CTRL_RST;
         chg <= BCC_CHG_RST;
         stop_pulse <= 1'b0;
      end else begin
         stop_pulse <= reg_wr_in && (reg_addr_in == BCC_OFS_CTRL) &&
                       reg_wdata_in[BCC_CTRL_TRK_STOP];
         if (reg_wr_in && reg_addr_in == BCC_OFS_CTRL) begin
            ctrl <= reg_wdata_in & 32'h0000_000d;
         end
         if (reg_wr_in && reg_addr_in == BCC_OFS_CHG) begin
            chg <= reg_wdata_in & 32'h0000_07f7;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         coin_prog <= BCC_COIN_RST;
      end else if (reg_wr_in && reg_addr_in == BCC_OFS_COIN && pwr_on) begin
         coin_prog <= reg_wdata_in[BCC_COIN_VSEL_LSB +: 3];
      end
   end

   // Read port: data in the cycle after the strobe, unmapped reads zero
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         reg_rdata_out <= 32'h0000_0000;
      end else if (reg_rd_in) begin
         unique case (reg_addr_in)
            BCC_OFS_CTRL: reg_rdata_out <= ctrl;
            BCC_OFS_CHG: reg_rdata_out <= chg;
            BCC_OFS_STATUS: reg_rdata_out <= {21'h0, usb_high, sense,
                                              mode, state};
            BCC_OFS_COIN: reg_rdata_out <= {29'h0, coin_prog};
            default: reg_rdata_out <= 32'h0000_0000;
         endcase
      end else begin
         reg_rdata_out <= 32'h0000_0000;
      end
   end

   // Trickle sequence state
   always_comb begin
      next_state = state;
      unique case (state)
         BCC_ST_IDLE: begin
            if (sense.charger_valid && !valid_q && trickle_allowed) begin
               next_state = sense.above_operate ? BCC_ST_NORMAL
                                                : BCC_ST_TRICKLE;
            end
         end
         BCC_ST_TRICKLE: begin
            if (ctrl[BCC_CTRL_DONE] || stop_pulse || tmo_cnt == TMO_LAST ||
                !sense.charger_valid || !trickle_allowed) begin
               next_state = BCC_ST_DONE;
            end else if (ctrl[BCC_CTRL_CHG_EN]) begin
               next_state = BCC_ST_NORMAL;
            end
         end
         BCC_ST_NORMAL: begin
            if (!sense.charger_valid) begin
               next_state = BCC_ST_IDLE;
            end
         end
         BCC_ST_DONE: begin
            if (!sense.charger_valid) begin
               next_state = BCC_ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         state <= BCC_ST_IDLE;
         valid_q <= 1'b0;
      end else begin
         state <= next_state;
         valid_q <= sense.charger_valid && strap_taken; // Plug at reset
      end
   end

   // Timeout counter runs only during the trickle cycle
   always_ff @(posedge clk_in) begin
      if (!rstn_in || state != BCC_ST_TRICKLE) begin
         tmo_cnt <= 32'h0000_0000;
      end else begin
         tmo_cnt <= tmo_cnt + 32'h0000_0001;
      end
   end

   // Trickle current and power-up request
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         trickle_isel_out <= 3'h0;
         power_up_req_out <= 1'b0;
      end else begin
         if (state == BCC_ST_TRICKLE) begin
            trickle_isel_out <= (sense.above_low && !single_path) ?
                                BCC_TSEL_MAX : BCC_TSEL_70MA;
         end else begin
            trickle_isel_out <= chg[BCC_CHG_TSEL_LSB +: 3];
         end
         power_up_req_out <= !pwr_on && sense.charger_valid &&
                             sense.above_operate &&
                             (state == BCC_ST_TRICKLE ||
                              state == BCC_ST_NORMAL ||
                              next_state == BCC_ST_NORMAL);
      end
   end

   // Charge settings; the current setting is clipped to fourteen steps except the full-on code
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         charge_vsel_out <= 3'h0;
         charge_isel_out <= 4'h0;
      end else begin
         charge_vsel_out <= chg[BCC_CHG_VSEL_LSB +: 3];
         if (chg[BCC_CHG_ISEL_LSB +: 4] == BCC_ISEL_FULL_ON ||
             chg[BCC_CHG_ISEL_LSB +: 4] <= BCC_ISEL_MAX_STEP) begin
            charge_isel_out <= chg[BCC_CHG_ISEL_LSB +: 4];
         end else begin
            charge_isel_out <= BCC_ISEL_MAX_STEP;
         end
      end
   end

   // Pass transistor pattern
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         fet_out <= '0;
         dead_batt_ok_out <= 1'b0;
      end else begin
         // no dead-battery support in single path
         dead_batt_ok_out <= strap_taken && !single_path &&
                             mode != BCC_MODE_RESERVED;
         if (ctrl[BCC_CTRL_ACC_SUP] && sense.batt_present &&
             !sense.charger_valid) begin
            fet_out <= 4'b1110;
         end else if (!sense.batt_present || !sense.above_low) begin
            fet_out.charge_control_fet <= sense.charger_valid;
            fet_out.charger_clamp_fet <= sense.charger_valid &&
                                         !sense.charger_over_volt;
            fet_out.battery_switch_fet <= 1'b0;
            fet_out.trickle_src_en <= state == BCC_ST_TRICKLE;
         end else begin
            fet_out.charge_control_fet <= sense.charger_valid;
            fet_out.charger_clamp_fet <= sense.charger_valid &&
                                         !sense.charger_over_volt;
            fet_out.battery_switch_fet <= 1'b1;
            fet_out.trickle_src_en <= 1'b0;
         end
      end
   end

   // Coin cell: preset voltage and reduced current when not on
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         coin_vsel_out <= BCC_COIN_RST;
         coin_low_ilim_out <= 1'b1;
      end else begin
         coin_vsel_out <= coin_prog;
         coin_low_ilim_out <= !pwr_on;
      end
   end

   // Assertions
   property p_clamp_ov;
      @(posedge clk_in) disable iff (!rstn_in)
      sense.charger_over_volt |=> !fet_out.charger_clamp_fet;
   endproperty
   a_clamp_ov: assert property (p_clamp_ov) else $error("clamp on");

   property p_acc;
      @(posedge clk_in) disable iff (!rstn_in)
      (ctrl[BCC_CTRL_ACC_SUP] && sense.batt_present && !sense.charger_valid)
      |=> fet_out == 4'b1110;
   endproperty
   a_acc: assert property (p_acc) else $error("acc pattern");

   property p_dead;
      @(posedge clk_in) disable iff (!rstn_in)
      (!sense.batt_present && !ctrl[BCC_CTRL_ACC_SUP])
      |=> !fet_out.battery_switch_fet;
   endproperty
   a_dead: assert property (p_dead) else $error("switch on dead");

   property p_low;
      @(posedge clk_in) disable iff (!rstn_in)
      (state == BCC_ST_TRICKLE && !sense.above_low)
      |=> trickle_isel_out == BCC_TSEL_70MA;
   endproperty
   a_low: assert property (p_low) else $error("low level");

   property p_high;
      @(posedge clk_in) disable iff (!rstn_in)
      (state == BCC_ST_TRICKLE && sense.above_low && !single_path)
      |=> trickle_isel_out == BCC_TSEL_MAX;
   endproperty
   a_high: assert property (p_high) else $error("high level");

   property p_single;
      @(posedge clk_in) disable iff (!rstn_in)
      (state == BCC_ST_TRICKLE && single_path)
      |=> trickle_isel_out == BCC_TSEL_70MA;
   endproperty
   a_single: assert property (p_single) else $error("single step");

   property p_se1;
      @(posedge clk_in) disable iff (!rstn_in)
      (single_path && usb_high) |=> state != BCC_ST_TRICKLE;
   endproperty
   a_se1: assert property (p_se1) else $error("trickle se1");

   property p_stop;
      @(posedge clk_in) disable iff (!rstn_in)
      (state == BCC_ST_TRICKLE && stop_pulse) |=> state == BCC_ST_DONE;
   endproperty
   a_stop: assert property (p_stop) else $error("stop lost");

   property p_mode_hold;
      @(posedge clk_in) disable iff (!rstn_in)
      strap_taken |=> $stable(mode);
   endproperty
   a_mode_hold: assert property (p_mode_hold) else $error("mode moved");

   property p_isel;
      @(posedge clk_in) disable iff (!rstn_in)
      1'b1 |=> charge_isel_out == $past(chg[BCC_CHG_ISEL_LSB +: 4]);
   endproperty
   a_isel: assert property (p_isel) else $error("isel code");

   c_trickle: cover property (@(posedge clk_in) state == BCC_ST_TRICKLE);
   c_skip: cover property (@(posedge clk_in)
      state == BCC_ST_IDLE ##1 state == BCC_ST_NORMAL);
   c_acc: cover property (@(posedge clk_in) fet_out == 4'b1110);

endmodule

// ==== verif/bcc_batt_model.sv ====
/*
 Battery and charger model: a battery level that rises while the
 device lets charge current flow, reported as comparator bits.
 Assumes the bench plugs the charger and may load or freeze the level.
*/
module bcc_batt_model
   import bcc_pkg::*;
#(
   parameter int LOW_LVL = 30,
   parameter int OP_LVL = 90
)
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rstn_in,
   // Bench control
   input wire logic plug_in,
   input wire logic ovp_in,
   input wire logic present_in,
   input wire logic load_in,
   input wire logic [7:0] load_lvl_in,
   // Device side
   input wire bcc_fet_t fet_in,
   input wire logic [2:0] trickle_isel_in,
   output bcc_sense_t sense_out
);
   logic [7:0] lvl;
   logic flow;

   // Current flows only through a conducting source or switch
   assign flow = fet_in.trickle_src_en | fet_in.battery_switch_fet;

   // Load holds the level, so a bench can freeze the battery
   always_ff @(posedge clk_in) begin
      if (!rstn_in || load_in) begin
         lvl <= load_lvl_in;
      end else if (plug_in && flow && lvl < 8'd240) begin
         lvl <= lvl + 8'(trickle_isel_in);
      end
   end

   // Comparators as the analog side reports them
   assign sense_out = '{plug_in, ovp_in, present_in,
                        32'(lvl) > LOW_LVL, 32'(lvl) > OP_LVL};
endmodule

// ==== verif/testbench.sv ====
/*
 Self-checking bench for the charger control block with a battery model.
 Assumes the register port answers one cycle after a read strobe.
*/
module testbench
   import bcc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {
      logic [31:0] d;
      logic [2:0] v;
      logic [3:0] i;
   } bcc_row_t;

   logic clk, rstn, wr, rd, usb, pwr, plug, ovp, pres, load;
   logic [3:0] addr, strap, isel;
   logic [31:0] wdata, rdata, word;
   logic [7:0] lvl;
   logic [2:0] vsel, tsel, cvsel;
   logic pwr_req, dead_ok, low_ilim;
   bcc_sense_t sense;
   bcc_fet_t fet;
   int err_total, checks_done, n;
   bcc_row_t rows [4] = '{'{32'h0000_0000, 3'h0, 4'h0},
      '{32'h0000_00f3, 3'h3, 4'hf}, '{32'h0000_00e7, 3'h7, 4'he},
      '{32'h0000_0715, 3'h5, 4'h1}};

   // Short trickle timeout keeps the run brief
   bcc_top #(.TRK_TIMEOUT_CYC(50)) bcc_top_inst (.clk_in(clk),
      .rstn_in(rstn), .reg_addr_in(addr), .reg_wdata_in(wdata),
      .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
      .strap_upper_hi_in(strap[3]), .strap_upper_lo_in(strap[2]),
      .strap_lower_hi_in(strap[1]), .strap_lower_lo_in(strap[0]),
      .sense_in(sense), .usb_both_lines_high_in(usb),
      .power_on_in(pwr), .fet_out(fet), .charge_vsel_out(vsel),
      .charge_isel_out(isel), .trickle_isel_out(tsel),
      .power_up_req_out(pwr_req), .dead_batt_ok_out(dead_ok),
      .coin_vsel_out(cvsel), .coin_low_ilim_out(low_ilim));

   bcc_batt_model bcc_batt_model_inst (.clk_in(clk), .rstn_in(rstn),
      .plug_in(plug), .ovp_in(ovp), .present_in(pres), .load_in(load),
      .load_lvl_in(lvl), .fet_in(fet), .trickle_isel_in(tsel),
      .sense_out(sense));

   // Free-running 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic tick(int k);
      repeat (k) @(posedge clk);
   endtask

   // One-cycle write strobe, then a quiet cycle
   task automatic wr_reg(logic [3:0] a, logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      tick(1);
      wr <= 1'b0;
      tick(1);
   endtask

   // Read data are taken in the one cycle that they stand
   task automatic rd_reg(logic [3:0] a);
      addr <= a;
      rd <= 1'b1;
      tick(1);
      rd <= 1'b0;
      tick(1);
      word = rdata;
   endtask

   task automatic do_reset();
      rstn <= 1'b0;
      tick(4);
      rstn <= 1'b1;
      tick(8);
   endtask

   // Straps settle during reset; the charger plugs just after it
   task automatic plug_at(logic [7:0] l, logic hold);
      plug <= 1'b0;
      lvl <= l;
      load <= 1'b1;
      do_reset();
      load <= hold;
      plug <= 1'b1;
      tick(6);
      rd_reg(BCC_OFS_STATUS);
   endtask

   function automatic logic [1:0] pins(int l);
      return (l == 0) ? 2'b01 : (l == 2) ? 2'b10 : 2'b00;
   endfunction

   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Hang guard, well past the expected run length
   initial begin
      #100us;
      err_total++;
      $display("FAIL watchdog expired");
      finish_test();
   end

   initial begin
      {rstn, wr, rd, usb, pwr, plug, ovp, pres, load} = '0;
      addr = '0;
      wdata = '0;
      lvl = '0;
      strap = 4'h1;
      err_total = 0;
      checks_done = 0;
      do_reset();
      check("fet", 32'(fet), 0);
      check("chg", {vsel, isel, tsel, pwr_req}, 0);
      check("coin", {cvsel, low_ilim}, 1);
      $display("test reset done");
      // Every strap pair, shared and separate input
      for (int u = 0; u < 3; u++) begin
         for (int l = 0; l < 3; l++) begin
            strap <= {pins(u), pins(l)};
            do_reset();
            rd_reg(BCC_OFS_STATUS);
            n = (u == 0) ? 6 : l + 3 * (u - 1);
            check("mode", 32'(word[4:2]), n);
            check("deadok", 32'(dead_ok), u != 0 && l != 1);
         end
      end
      // Last strap pair was separate input serial path
      strap <= 4'h1;
      tick(8);
      rd_reg(BCC_OFS_STATUS);
      check("held", 32'(word[4:2]), 32'(BCC_MODE_SEP_SERIAL));
      $display("test straps done");
      foreach (rows[k]) begin
         wr_reg(BCC_OFS_CHG, rows[k].d);
         tick(1);
         check("vsel", 32'(vsel), 32'(rows[k].v));
         check("isel", 32'(isel), 32'(rows[k].i));
         check("tsel", 32'(tsel), 32'(rows[k].d[10:8]));
         rd_reg(BCC_OFS_CHG);
         check("chgrd", 32'(word[10:0]), rows[k].d);
      end
      rd_reg(4'h7);
      check("unmapped", word, 0);
      // Accessory supply needs a battery and no charger
      pres <= 1'b1;
      wr_reg(BCC_OFS_CTRL, 32'h0000_0004);
      tick(3);
      check("acc", 32'(fet), 32'h0000_000e);
      $display("test settings done");
      pres <= 1'b0;
      strap <= 4'h1;
      plug_at(8'h00, 1'b1);
      check("absent", {fet.battery_switch_fet, fet.trickle_src_en}, 1);
      ovp <= 1'b1;
      tick(6);
      check("clamp", 32'(fet.charger_clamp_fet), 0);
      ovp <= 1'b0;
      pres <= 1'b1;
      plug_at(8'h00, 1'b0);
      check("start", 32'(word[1:0]), 1);
      check("low", 32'(tsel), 32'(BCC_TSEL_70MA));
      check("dead", {fet.battery_switch_fet, fet.trickle_src_en}, 1);
      for (n = 0; n < 100 && tsel !== BCC_TSEL_MAX; n++) tick(1);
      check("high", 32'(tsel), 32'(BCC_TSEL_MAX));
      check("switch", 32'(fet.battery_switch_fet), 1);
      for (n = 0; n < 100 && pwr_req !== 1'b1; n++) tick(1);
      check("pwrup", 32'(pwr_req), 1);
      rd_reg(BCC_OFS_STATUS);
      check("stay", 32'(word[1:0]), 1);
      wr_reg(BCC_OFS_CTRL, 32'h0000_0001);
      tick(2);
      rd_reg(BCC_OFS_STATUS);
      check("normal", 32'(word[1:0]), 2);
      plug_at(8'h00, 1'b1);
      tick(60);
      rd_reg(BCC_OFS_STATUS);
      check("timeout", 32'(word[1:0]), 3);
      plug_at(8'h00, 1'b1);
      wr_reg(BCC_OFS_CTRL, 32'h0000_0002);
      tick(2);
      rd_reg(BCC_OFS_STATUS);
      check("swstop", 32'(word[1:0]), 3);
      plug_at(8'h00, 1'b1);
      wr_reg(BCC_OFS_CTRL, 32'h0000_0008);
      tick(2);
      rd_reg(BCC_OFS_STATUS);
      check("complete", 32'(word[1:0]), 3);
      plug_at(8'hc8, 1'b1);
      check("skip", {word[1:0], pwr_req}, 32'h0000_0005);
      $display("test trickle done");
      strap <= 4'h0;
      usb <= 1'b1;
      plug_at(8'h00, 1'b1);
      check("usbhigh", 32'(word[1:0]), 0);
      usb <= 1'b0;
      plug_at(8'h32, 1'b1);
      check("single", 32'(word[1:0]), 1);
      check("nostep", 32'(tsel), 32'(BCC_TSEL_70MA));
      $display("test single done");
      wr_reg(BCC_OFS_COIN, 32'h0000_0005);
      tick(3);
      check("coinoff", {cvsel, low_ilim}, 1);
      pwr <= 1'b1;
      tick(4);
      wr_reg(BCC_OFS_COIN, 32'h0000_0005);
      tick(3);
      check("coinon", {cvsel, low_ilim}, 32'h0000_000a);
      $display("test coin done");
      finish_test();
   end
endmodule
